/* rtl/bcd_pkg.sv */
// Package holding offsets, reset values and types of the bridge header block.
package bcd_pkg;

    // ------------------------------------------------------------------
    // Configuration offsets.
    // ------------------------------------------------------------------
    localparam logic [7:0] BCD_OFS_REV      = 8'h08; // Revision byte.
    localparam logic [7:0] BCD_OFS_PIF      = 8'h09; // Programming interface.
    localparam logic [7:0] BCD_OFS_SUBCLASS = 8'h0A; // Sub-class byte.
    localparam logic [7:0] BCD_OFS_BASECLS  = 8'h0B; // Base class byte.
    localparam logic [7:0] BCD_OFS_CLS      = 8'h0C; // Cache line size.
    localparam logic [7:0] BCD_OFS_UPLAT    = 8'h0D; // Upstream latency.
    localparam logic [7:0] BCD_OFS_HDR      = 8'h0E; // Header layout.
    localparam logic [7:0] BCD_OFS_UPBUS    = 8'h18; // Upstream bus number.
    localparam logic [7:0] BCD_OFS_DNBUS    = 8'h19; // Downstream bus number.
    localparam logic [7:0] BCD_OFS_HIBUS    = 8'h1A; // Highest bus below.
    localparam logic [7:0] BCD_OFS_DNLAT    = 8'h1B; // Downstream latency.

    // ------------------------------------------------------------------
    // Fixed values and reset values.
    // ------------------------------------------------------------------
    localparam logic [7:0] BCD_REV_VAL      = 8'h01; // Arbitrary revision.
    localparam logic [7:0] BCD_PIF_VAL      = 8'h00; // Standard bridge.
    localparam logic [7:0] BCD_SUBCLASS_VAL = 8'h04; // Bridge to bridge.
    localparam logic [7:0] BCD_BASECLS_VAL  = 8'h06; // Bridge device.
    localparam logic [7:0] BCD_CLS_VAL      = 8'h00; // Never used.
    localparam logic [7:0] BCD_HDR_VAL      = 8'h01; // Single function.
    localparam logic [7:0] BCD_RW_RST       = 8'h00; // Writable reset value.
    localparam logic [7:0] BCD_ALL_ONES     = 8'hFF; // Master abort data.
    localparam logic [7:0] BCD_TIMER_MASK   = 8'hF8; // Timer bits 7:3.
    localparam int         BCD_LAT_LSB      = 3;     // Latency field LSB.
    localparam logic [7:0] BCD_CNT_ZERO     = 8'h00; // Counter empty.

    // ------------------------------------------------------------------
    // Types.
    // ------------------------------------------------------------------
    // Configuration access from the hub side.
    typedef struct packed {
        logic       wr;    // One for write, zero for read.
        logic [7:0] addr;  // Byte offset.
        logic [7:0] wdata; // Write data.
    } bcd_cfg_req_t;

    // Type 1 request: bus number being addressed.
    typedef struct packed {
        logic [7:0] bus;
    } bcd_t1_req_t;

    // Routing decision for a Type 1 request.
    typedef enum logic [1:0] {
        BCD_ROUTE_TYPE0   = 2'b00, // Convert to Type 0 or special cycle.
        BCD_ROUTE_FORWARD = 2'b01, // Pass on as Type 1.
        BCD_ROUTE_ABORT   = 2'b10  // Master abort, all ones.
    } bcd_route_t;

    // Burst ownership state machine.
    typedef enum logic [1:0] {
        BCD_ST_IDLE  = 2'b00, // Bus not owned.
        BCD_ST_BURST = 2'b01  // Frame asserted.
    } bcd_state_t;

endpackage : bcd_pkg

/* rtl/bcd_bridge_header.sv */
// Bridge header registers, Type 1 decode and downstream latency timer.
`timescale 1ns/10ps
`default_nettype none

module bcd_bridge_header
    import bcd_pkg::*;
(
    input  wire logic         sys_clk_in,      // Bus clock, 25 MHz.
    input  wire logic         srst_in,         // Synchronous reset.
    input  wire logic         cfg_valid_in,    // Config access strobe.
    input  wire bcd_cfg_req_t cfg_req_in,      // Config access fields.
    output logic              cfg_rvalid_out,  // Read data valid pulse.
    output logic [7:0]        cfg_rdata_out,   // Read data.
    input  wire logic         t1_valid_in,     // Type 1 request strobe.
    input  wire bcd_t1_req_t  t1_req_in,       // Type 1 bus number.
    output logic              t1_done_out,     // Decision valid pulse.
    output bcd_route_t        t1_route_out,    // Decision.
    output logic [7:0]        t1_abort_data_out, // Abort read data.
    input  wire logic         burst_start_in,  // Start master cycle.
    input  wire logic         burst_last_in,   // Data ran out.
    input  wire logic         grant_in,        // Internal bus grant.
    output logic              frame_out,       // Frame active high.
    output logic              lat_expired_out  // Counter at zero during a burst.
);

    // ------------------------------------------------------------------
    // Register storage.
    // ------------------------------------------------------------------
    logic [7:0] upstream_latency_timer_r;   // Timer field, no effect.
    logic [7:0] upstream_bus_number_r;      // Hub side bus number.
    logic [7:0] downstream_bus_number_r;    // Secondary bus number.
    logic [7:0] highest_bus_below_r;        // Subordinate bus number.
    logic [7:0] downstream_latency_timer_r; // Latency field in 7:3.
    logic [7:0] burst_latency_counter_r;    // Live latency count.
    bcd_state_t state_r;                    // Burst state.
    logic       cfg_wr;                     // Write strobe.

    assign cfg_wr = cfg_valid_in & cfg_req_in.wr;

    // ------------------------------------------------------------------
    // Writable registers.
    // ------------------------------------------------------------------
    // Each writable byte clears on reset and changes only on a write
    // to its own offset; all other offsets drop the write.
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            upstream_latency_timer_r   <= BCD_RW_RST;
            upstream_bus_number_r      <= BCD_RW_RST;
            downstream_bus_number_r    <= BCD_RW_RST;
            highest_bus_below_r        <= BCD_RW_RST;
            downstream_latency_timer_r <= BCD_RW_RST;
        end else if (cfg_wr) begin
            unique case (cfg_req_in.addr)
                BCD_OFS_UPLAT: begin
                    // Reserved bits 2:0 are held at zero.
                    upstream_latency_timer_r <=
                        cfg_req_in.wdata & BCD_TIMER_MASK;
                end
                BCD_OFS_UPBUS: begin
                    upstream_bus_number_r <= cfg_req_in.wdata;
                end
                BCD_OFS_DNBUS: begin
                    downstream_bus_number_r <= cfg_req_in.wdata;
                end
                BCD_OFS_HIBUS: begin
                    highest_bus_below_r <= cfg_req_in.wdata;
                end
                BCD_OFS_DNLAT: begin
                    downstream_latency_timer_r <=
                        cfg_req_in.wdata & BCD_TIMER_MASK;
                end
                default: begin
                    // Read-only and unmapped offsets ignore writes.
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read path.
    // ------------------------------------------------------------------
    // Read data appears one cycle after the strobe, with a valid pulse.
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            cfg_rvalid_out <= 1'b0;
            cfg_rdata_out  <= 8'h00;
        end else begin
            cfg_rvalid_out <= cfg_valid_in & ~cfg_req_in.wr;
            unique case (cfg_req_in.addr)
                BCD_OFS_REV:      cfg_rdata_out <= BCD_REV_VAL;
                BCD_OFS_PIF:      cfg_rdata_out <= BCD_PIF_VAL;
                BCD_OFS_SUBCLASS: cfg_rdata_out <= BCD_SUBCLASS_VAL;
                BCD_OFS_BASECLS:  cfg_rdata_out <= BCD_BASECLS_VAL;
                BCD_OFS_CLS:      cfg_rdata_out <= BCD_CLS_VAL;
                BCD_OFS_UPLAT:    cfg_rdata_out <= upstream_latency_timer_r;
                BCD_OFS_HDR:      cfg_rdata_out <= BCD_HDR_VAL;
                BCD_OFS_UPBUS:    cfg_rdata_out <= upstream_bus_number_r;
                BCD_OFS_DNBUS:    cfg_rdata_out <= downstream_bus_number_r;
                BCD_OFS_HIBUS:    cfg_rdata_out <= highest_bus_below_r;
                BCD_OFS_DNLAT:    cfg_rdata_out <= downstream_latency_timer_r;
                default:          cfg_rdata_out <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Type 1 decode.
    // ------------------------------------------------------------------
    // A match on the downstream bus is converted, a bus inside the
    // range behind it is forwarded, anything else is master aborted.
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            t1_done_out       <= 1'b0;
            t1_route_out      <= BCD_ROUTE_ABORT;
            t1_abort_data_out <= 8'h00;
        end else begin
            t1_done_out <= t1_valid_in;
            if (t1_valid_in) begin
                if (t1_req_in.bus == downstream_bus_number_r) begin
                    t1_route_out      <= BCD_ROUTE_TYPE0;
                    t1_abort_data_out <= 8'h00;
                end else if (t1_req_in.bus > downstream_bus_number_r &&
                             t1_req_in.bus <= highest_bus_below_r) begin
                    t1_route_out      <= BCD_ROUTE_FORWARD;
                    t1_abort_data_out <= 8'h00;
                end else begin
                    t1_route_out      <= BCD_ROUTE_ABORT;
                    t1_abort_data_out <= BCD_ALL_ONES;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Burst ownership and latency counter.
    // ------------------------------------------------------------------
    // The counter loads with the field times eight as frame rises, then
    // counts down each clock, holding at zero. Frame drops when data runs out, or when
    // the counter is empty and the grant has gone.
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            state_r                 <= BCD_ST_IDLE;
            frame_out               <= 1'b0;
            burst_latency_counter_r <= BCD_CNT_ZERO;
            lat_expired_out         <= 1'b0;
        end else begin
            unique case (state_r)
                BCD_ST_IDLE: begin
                    lat_expired_out <= 1'b0;
                    if (burst_start_in && grant_in) begin
                        state_r                 <= BCD_ST_BURST;
                        frame_out               <= 1'b1;
                        burst_latency_counter_r <=
                            {downstream_latency_timer_r[7:BCD_LAT_LSB],
                             3'b000};
                    end
                end
                BCD_ST_BURST: begin
                    if (burst_latency_counter_r != BCD_CNT_ZERO) begin
                        burst_latency_counter_r <=
                            burst_latency_counter_r - 8'h01;
                    end
                    lat_expired_out <=
                        (burst_latency_counter_r <= 8'h01);
                    if (burst_last_in ||
                        (burst_latency_counter_r == BCD_CNT_ZERO &&
                         !grant_in)) begin
                        state_r   <= BCD_ST_IDLE;
                        frame_out <= 1'b0;
                    end
                    // Otherwise grant held keeps the burst going.
                end
                default: begin
                    state_r   <= BCD_ST_IDLE;
                    frame_out <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    sequence s_write_bus(logic [7:0] ofs);
        cfg_valid_in && cfg_req_in.wr && cfg_req_in.addr == ofs;
    endsequence

    property p_rev_fixed;
        @(posedge sys_clk_in) disable iff (srst_in)
        (cfg_valid_in && !cfg_req_in.wr && cfg_req_in.addr == BCD_OFS_REV)
            |=> cfg_rvalid_out && cfg_rdata_out == BCD_REV_VAL;
    endproperty
    a_rev_fixed: assert property (p_rev_fixed)
        else $error("Revision byte read wrong.");

    property p_class_fixed;
        @(posedge sys_clk_in) disable iff (srst_in)
        (cfg_valid_in && !cfg_req_in.wr &&
         cfg_req_in.addr == BCD_OFS_BASECLS) |=> cfg_rdata_out == 8'h06;
    endproperty
    a_class_fixed: assert property (p_class_fixed)
        else $error("Base class read wrong.");

    property p_dnbus_write;
        @(posedge sys_clk_in) disable iff (srst_in)
        s_write_bus(BCD_OFS_DNBUS)
            |=> downstream_bus_number_r == $past(cfg_req_in.wdata);
    endproperty
    a_dnbus_write: assert property (p_dnbus_write)
        else $error("Downstream bus number not written.");

    property p_dnbus_hold;
        @(posedge sys_clk_in) disable iff (srst_in)
        !(cfg_wr && cfg_req_in.addr == BCD_OFS_DNBUS)
            |=> $stable(downstream_bus_number_r);
    endproperty
    a_dnbus_hold: assert property (p_dnbus_hold)
        else $error("Downstream bus number changed without write.");

    property p_type0;
        @(posedge sys_clk_in) disable iff (srst_in)
        (t1_valid_in && t1_req_in.bus == downstream_bus_number_r)
            |=> t1_done_out && t1_route_out == BCD_ROUTE_TYPE0;
    endproperty
    a_type0: assert property (p_type0)
        else $error("Matching Type 1 not converted.");

    property p_abort;
        @(posedge sys_clk_in) disable iff (srst_in)
        // A match on the downstream bus always converts, even when the
        // highest bus below is programmed under it.
        (t1_valid_in && t1_req_in.bus != downstream_bus_number_r &&
         (t1_req_in.bus < downstream_bus_number_r ||
          t1_req_in.bus > highest_bus_below_r))
            |=> t1_route_out == BCD_ROUTE_ABORT &&
                t1_abort_data_out == BCD_ALL_ONES;
    endproperty
    a_abort: assert property (p_abort)
        else $error("Out of range Type 1 not aborted.");

    property p_load;
        @(posedge sys_clk_in) disable iff (srst_in)
        $rose(frame_out) |-> burst_latency_counter_r ==
            {$past(downstream_latency_timer_r[7:3]), 3'b000};
    endproperty
    a_load: assert property (p_load)
        else $error("Latency counter not loaded at frame start.");

    property p_expire_drop;
        @(posedge sys_clk_in) disable iff (srst_in)
        (state_r == BCD_ST_BURST &&
         burst_latency_counter_r == BCD_CNT_ZERO && !grant_in)
            |=> !frame_out;
    endproperty
    a_expire_drop: assert property (p_expire_drop)
        else $error("Frame held after expiry without grant.");

    property p_grant_keep;
        @(posedge sys_clk_in) disable iff (srst_in)
        (frame_out && grant_in && !burst_last_in) |=> frame_out;
    endproperty
    a_grant_keep: assert property (p_grant_keep)
        else $error("Frame dropped while grant held.");

endmodule : bcd_bridge_header

`default_nettype wire

/* tb/bcd_host_model.sv */
// Host controller model issuing configuration and Type 1 requests.
`timescale 1ns/10ps
`default_nettype none

module bcd_host_model
    import bcd_pkg::*;
(
    input  wire logic       sys_clk_in,    // Bus clock.
    output logic            cfg_valid_out, // Access strobe.
    output bcd_cfg_req_t    cfg_req_out,   // Access fields.
    input  wire logic       cfg_rvalid_in, // Read data valid.
    input  wire logic [7:0] cfg_rdata_in,  // Read data.
    output logic            t1_valid_out,  // Type 1 strobe.
    output bcd_t1_req_t     t1_req_out,    // Type 1 bus number.
    input  wire logic       t1_done_in     // Decision valid.
);
    // Idle request lines at time zero.
    initial begin
        cfg_valid_out = 1'b0;
        cfg_req_out   = '0;
        t1_valid_out  = 1'b0;
        t1_req_out    = '0;
    end

    // One byte access; released fields are scrambled so stale data shows.
    task automatic cfg_xfer(input logic wr, input logic [7:0] addr,
                            input logic [7:0] wdata,
                            output logic [7:0] rd, output logic ok);
        @(posedge sys_clk_in);
        #1;
        cfg_valid_out = 1'b1;
        cfg_req_out   = '{wr, addr, wdata};
        @(posedge sys_clk_in);
        #1;
        cfg_valid_out = 1'b0;
        cfg_req_out   = ~cfg_req_out;
        rd            = cfg_rdata_in;
        ok            = cfg_rvalid_in;
    endtask : cfg_xfer

    // One Type 1 request; the decision is sampled one cycle later.
    task automatic t1_xfer(input logic [7:0] bus, output logic ok);
        @(posedge sys_clk_in);
        #1;
        t1_valid_out = 1'b1;
        t1_req_out   = '{bus};
        @(posedge sys_clk_in);
        #1;
        t1_valid_out = 1'b0;
        t1_req_out   = ~t1_req_out;
        ok           = t1_done_in;
    endtask : t1_xfer
endmodule : bcd_host_model

`default_nettype wire

/* tb/bridge_config_header_bus_decode_tb.sv */
// Self-checking bench for the bridge header block.
`timescale 1ns/10ps
`default_nettype none

module bridge_config_header_bus_decode_tb
    import bcd_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals.
    // ------------------------------------------------------------------
    typedef struct {
        logic [7:0] addr, rst, wdata, exp;
    } bcd_tb_row_t;
    typedef struct {
        logic [7:0] bus, route, data;
    } bcd_tb_t1_t;
    logic         clk = 1'b0;   // Bus clock.
    logic         srst;         // Reset.
    logic         cv, rv, tv, td, st, la, gr, fr, ex; // Handshakes.
    bcd_cfg_req_t creq;         // Access fields.
    bcd_t1_req_t  treq;         // Type 1 bus.
    bcd_route_t   route;        // Decision.
    logic [7:0]   rdata, adata, rd; // Data bytes.
    logic         ok;           // Answer seen.
    int           fail_count = 0;
    int           n_checks = 0;
    int           cycles = 0;
    int           n;
    // Register rows: offset, reset value, write value, read back.
    bcd_tb_row_t rows[12] = '{
        '{8'h08, BCD_REV_VAL, 8'hFF, BCD_REV_VAL},
        '{8'h09, 8'h00, 8'hFF, 8'h00},
        '{8'h0A, 8'h04, 8'hFF, 8'h04},
        '{8'h0B, 8'h06, 8'hFF, 8'h06},
        '{8'h0C, 8'h00, 8'hFF, 8'h00},
        '{8'h0D, 8'h00, 8'hFF, 8'hF8},
        '{8'h0E, 8'h01, 8'hFF, 8'h01},
        '{8'h18, 8'h00, 8'h5A, 8'h5A},
        '{8'h19, 8'h00, 8'h05, 8'h05},
        '{8'h1A, 8'h00, 8'h07, 8'h07},
        '{8'h1B, 8'h00, 8'h0F, 8'h08},
        '{8'h10, 8'h00, 8'hFF, 8'h00}};
    // Type 1 rows with downstream 05h and highest 07h.
    bcd_tb_t1_t t1s[5] = '{
        '{8'h05, 8'h00, 8'h00}, '{8'h06, 8'h01, 8'h00},
        '{8'h07, 8'h01, 8'h00}, '{8'h08, 8'h02, 8'hFF},
        '{8'h04, 8'h02, 8'hFF}};

    // Clock of 40 ns period.
    always #20 clk = ~clk;

    // ------------------------------------------------------------------
    // Design and host model.
    // ------------------------------------------------------------------
    bcd_bridge_header u_dut (
        .sys_clk_in(clk), .srst_in(srst), .cfg_valid_in(cv),
        .cfg_req_in(creq), .cfg_rvalid_out(rv), .cfg_rdata_out(rdata),
        .t1_valid_in(tv), .t1_req_in(treq), .t1_done_out(td),
        .t1_route_out(route), .t1_abort_data_out(adata),
        .burst_start_in(st), .burst_last_in(la), .grant_in(gr),
        .frame_out(fr), .lat_expired_out(ex));
    bcd_host_model u_host (
        .sys_clk_in(clk), .cfg_valid_out(cv), .cfg_req_out(creq),
        .cfg_rvalid_in(rv), .cfg_rdata_in(rdata), .t1_valid_out(tv),
        .t1_req_out(treq), .t1_done_in(td));

    // Compares one byte and reports a difference.
    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // Prints the counts and the verdict, then stops.
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize

    // Cuts a hang short well past the expected run length.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            summarize();
        end
    end

    // Starts one burst with grant; start drops after the taking edge.
    task automatic burst_go;
        @(posedge clk);
        #1;
        st = 1'b1;
        gr = 1'b1;
        @(posedge clk);
        #1;
        st = 1'b0;
        check("frame on", {7'h00, fr}, 8'h01);
        check("expired off", {7'h00, ex}, 8'h00);
    endtask : burst_go

    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        srst = 1'b1;
        {st, la, gr} = 3'b000;
        repeat (3) @(posedge clk);
        #1;
        srst = 1'b0;
        // Reset value, write, read back for every offset.
        foreach (rows[i]) begin
            u_host.cfg_xfer(1'b0, rows[i].addr, 8'h00, rd, ok);
            check("rvalid", {7'h00, ok}, 8'h01);
            check("reset value", rd, rows[i].rst);
            u_host.cfg_xfer(1'b1, rows[i].addr, rows[i].wdata, rd, ok);
            check("write answer", {7'h00, ok}, 8'h00);
            u_host.cfg_xfer(1'b0, rows[i].addr, 8'h00, rd, ok);
            check("read back", rd, rows[i].exp);
        end
        // Type 1 routing around the programmed bus range.
        foreach (t1s[i]) begin
            u_host.t1_xfer(t1s[i].bus, ok);
            check("t1 done", {7'h00, ok}, 8'h01);
            check("route", {6'h00, route}, t1s[i].route);
            check("abort data", adata, t1s[i].data);
        end
        // Grant held: ownership continues after expiry.
        burst_go();
        repeat (12) @(posedge clk);
        #1;
        check("frame held", {7'h00, fr}, 8'h01);
        check("expired", {7'h00, ex}, 8'h01);
        gr = 1'b0;
        @(posedge clk);
        #1;
        check("frame drop", {7'h00, fr}, 8'h00);
        // Grant withdrawn at once: frame lasts field times eight plus one.
        burst_go();
        gr = 1'b0;
        n = 0;
        while (fr === 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("frame length", 8'(n), 8'h09);
        // Data runs out: frame ends at the next edge.
        burst_go();
        la = 1'b1;
        @(posedge clk);
        #1;
        la = 1'b0;
        check("last drop", {7'h00, fr}, 8'h00);
        // Start without grant is not taken.
        gr = 1'b0;
        st = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        st = 1'b0;
        check("no grant", {7'h00, fr}, 8'h00);
        // Reset in mid-run clears a written bus number.
        u_host.cfg_xfer(1'b1, BCD_OFS_DNBUS, 8'h33, rd, ok);
        u_host.cfg_xfer(1'b0, BCD_OFS_DNBUS, 8'h00, rd, ok);
        check("bus before reset", rd, 8'h33);
        srst = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        srst = 1'b0;
        u_host.cfg_xfer(1'b0, BCD_OFS_DNBUS, 8'h00, rd, ok);
        check("bus after reset", rd, 8'h00);
        summarize();
    end
endmodule : bridge_config_header_bus_decode_tb

`default_nettype wire
